// [spc_map.vh]
/*
 * Register offsets, field positions, reset values and timing constants of the
 * serial port.
 * Assumes it is included by its bare name by the serial port core.
 */
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// Register addresses on the plain register port.
`define SPC_ADDR_W        4
`define SPC_OFS_STAT      4'h0
`define SPC_OFS_CFG_A     4'h1
`define SPC_OFS_CFG_B     4'h2
`define SPC_OFS_DATA      4'h3

// Status and control register fields.
`define SPC_ST_EN         15
`define SPC_ST_ROV        6
`define SPC_ST_TBF        1
`define SPC_ST_RBF        0

// Configuration register A fields.
`define SPC_A_SCKDIS      12
`define SPC_A_SDODIS      11
`define SPC_A_W16         10
`define SPC_A_SMP         9
`define SPC_A_EDGE        8
`define SPC_A_SLAVE_SELECT_PIN_ENABLE        7
`define SPC_A_CPOL        6
`define SPC_A_MST         5
`define SPC_A_MASK        16'h1FFF

// Configuration register B fields.
`define SPC_B_FRM         15
`define SPC_B_FSDIR       14
`define SPC_B_FSPOL       13
`define SPC_B_FSLATE      1
`define SPC_B_MASK        16'hE002

// Reset value of every register.
`define SPC_RST_VAL       16'h0000

// Frame sync pulse length in serial bit times.
`define SPC_FS_BITS       1

`endif

// [spc_port.v]
/*
 * Serial peripheral port with two configuration registers, a status register
 * and a data buffer, reached over a plain register port.
 * Assumes a single 50 MHz clock, a synchronous active-high reset, and pin
 * inputs that arrive asynchronously and are synchronised here.
 */
// Notes on behaviour
// [RL1] Master with clock disable leaves clock pin alone.
// [RL2] Data-out disable releases the data pin.
// [RL3] Word width selects sixteen or eight bits.
// [RL4] Master samples at period end or middle.
// [RL5] Software clears sample phase in slave.
// [RL6] Edge select picks which clock edge shifts.
// [RL7] Slave select pin used only when enabled.
// [RL8] Clock polarity sets idle and active levels.
// [RL9] Master select chooses clock generation role.
// [RL10] Secondary prescale ratio is eight minus code.
// [RL11] Primary prescale gives 1, 4, 16, 64.
// [RL12] Software never sets both prescales 1:1.
// [RL13] Software writes edge select zero when framed.
// [RL14] Software clears select enable when framed.
// [RL15] Framed mode uses select pin as sync.
// [RL16] Sync direction picks input or output.
// [RL17] Sync polarity picks active high or low.
// [RL18] Sync coincides with or precedes first bit.
// [RL19] Software never sets config B bit zero.
// [RL20] Unimplemented bits read back as zero.
// [RL21] Enable activates port and claims pins.
// [RL22] Unread receive data makes new data overflow.
// [RL23] Data write sets transmit full; load clears.
// [RL24] Receive load sets full; data read clears.
// [RL25] Master clock is clock over twice the prescale product.
// [RL26] Slave ignores prescale, uses external clock.
`timescale 1ns/1ps
`include "spc_map.vh"

module spc_port
(
	input  wire        clk_i,         // System clock.
	input  wire        srst_i,        // Synchronous reset, active high.
	input  wire [3:0]  addr_i,        // Register address.
	input  wire [15:0] wdata_i,       // Write data.
	input  wire        wr_i,          // Write strobe.
	input  wire        rd_i,          // Read strobe.
	output reg  [15:0] rdata_o,       // Read data, valid the cycle after rd_i.
	input  wire        sck_i,         // Serial clock pin input.
	output reg         sck_o,         // Serial clock pin output.
	output wire        sck_oe_n_o,    // Serial clock pin enable, low drives.
	input  wire        sdi_i,         // Serial data input pin.
	output reg         sdo_o,         // Serial data output pin.
	output wire        sdo_oe_n_o,    // Serial data output enable, low drives.
	input  wire        ss_i,          // Select or frame sync pin input.
	output reg         ss_o,          // Frame sync pin output.
	output wire        ss_oe_n_o      // Frame sync pin enable, low drives.
);

	// One-hot transfer states.
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SYNC = 3'b010;
	localparam [2:0] ST_XFER = 3'b100;

	// Software-visible registers.
	reg        en_q;                   // Module enable.
	reg        rov_q;                  // Receive overflow flag.
	reg        tbf_q;                  // Transmit buffer full.
	reg        rbf_q;                  // Receive buffer full.
	reg [15:0] cfga_q;                 // Configuration register A.
	reg [15:0] cfgb_q;                 // Configuration register B.
	reg [15:0] txb_q;                  // Transmit buffer.
	reg [15:0] rxb_q;                  // Receive buffer.

	// Shift engine.
	reg [2:0]  st_q;                   // Transfer state.
	reg [15:0] sr_q;                   // Shift register.
	reg [4:0]  bit_q;                  // Bit edges remaining.
	reg        ph_q;                   // Master half period: 0 leading, 1 trailing.
	reg        smp_q;                  // Captured input bit awaiting the next shift.
	reg [8:0]  div_q;                  // Prescale divider counter.
	reg        done_q;                 // One-cycle pulse: a word is received.

	// Pin synchronisers, two flops each.
	reg [1:0]  sck_s_q;
	reg [1:0]  sdi_s_q;
	reg [1:0]  ss_s_q;
	reg        sck_d1_q;               // Delayed synchronised clock for edge finding.
	reg        fs_d1_q;                // Delayed frame sync level.

	// Decoded configuration bits.
	wire mst    = cfga_q[`SPC_A_MST];
	wire cpol   = cfga_q[`SPC_A_CPOL];
	wire edge1  = cfga_q[`SPC_A_EDGE];
	wire w16    = cfga_q[`SPC_A_W16];
	wire input_sample_phase    = cfga_q[`SPC_A_SMP];
	wire frm    = cfgb_q[`SPC_B_FRM];
	wire fsdir  = cfgb_q[`SPC_B_FSDIR];
	wire fspol  = cfgb_q[`SPC_B_FSPOL];
	wire fslate = cfgb_q[`SPC_B_FSLATE];
	// Framed operation ignores edge select, so it behaves as zero.
	wire cke    = edge1 & ~frm;

	// Bit count for the selected width.
	function [4:0] width_bits;
		input w;
		begin
			width_bits = w ? 5'd16 : 5'd8; // RL3
		end
	endfunction

	// Half period in system cycles: primary ratio times secondary ratio.
	function [8:0] half_div;
		input [1:0] pp;
		input [2:0] sp;
		reg   [6:0] pr;
		reg   [3:0] sr;
		begin
			pr = 7'd1;
			sr = 4'd8 - {1'b0, sp}; // RL10
			case (pp)
				2'b11: pr = 7'd1; // RL11
				2'b10: pr = 7'd4;
				2'b01: pr = 7'd16;
				default: pr = 7'd64;
			endcase
			half_div = {2'b00, pr} * {5'b0, sr};
		end
	endfunction

	wire [8:0] ratio = half_div(cfga_q[1:0], cfga_q[4:2]);
	// One-cycle enable each serial half period; a 1:1 product ticks every cycle.
	wire       tick  = (div_q >= ratio - 9'd1) || (ratio == 9'd1); // RL25

	// Slave clock edges on the synchronised pin.
	wire sck_s   = sck_s_q[1];
	wire s_lead  = (sck_s != sck_d1_q) && (sck_s != cpol); // idle-to-active
	wire s_trail = (sck_s != sck_d1_q) && (sck_s == cpol); // active-to-idle
	// Slave select: active low and honoured only when enabled.
	wire ss_ok   = ~cfga_q[`SPC_A_SLAVE_SELECT_PIN_ENABLE] | ~ss_s_q[1]; // RL7
	// Frame sync input asserted level and its leading edge.
	wire fs_in   = (ss_s_q[1] == fspol);  // RL17
	wire fs_rise = fs_in & ~fs_d1_q;

	// Leading and trailing edges of the clock that drives the shift.
	wire e_lead  = mst ? (tick & ~ph_q) : (s_lead & ss_ok);   // RL26
	wire e_trail = mst ? (tick & ph_q)  : (s_trail & ss_ok);
	// Shift out on one edge, capture on the other.
	wire e_shift = cke ? e_trail : e_lead; // RL6
	wire e_cap   = cke ? e_lead : e_trail;

	wire [4:0] nbits = width_bits(w16);
	wire       rd_data = rd_i && (addr_i == `SPC_OFS_DATA);
	wire       wr_data = wr_i && (addr_i == `SPC_OFS_DATA);
	wire       start_ok = en_q & tbf_q & (st_q == ST_IDLE);

	// Pins belong to the port only while it is enabled.
	assign sck_oe_n_o = ~(en_q & mst & ~cfga_q[`SPC_A_SCKDIS]); // RL1 RL9 RL21
	assign sdo_oe_n_o = ~(en_q & ~cfga_q[`SPC_A_SDODIS]);       // RL2 RL21
	assign ss_oe_n_o  = ~(en_q & frm & ~fsdir);                 // RL15 RL16

	// Synchronise every pin input before use.
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sck_s_q  <= 2'b00;
			sdi_s_q  <= 2'b00;
			ss_s_q   <= 2'b11;
			sck_d1_q <= 1'b0;
			fs_d1_q  <= 1'b0;
		end
		else
		begin
			sck_s_q  <= {sck_s_q[0], sck_i};
			sdi_s_q  <= {sdi_s_q[0], sdi_i};
			ss_s_q   <= {ss_s_q[0], ss_i};
			sck_d1_q <= sck_s_q[1];
			fs_d1_q  <= fs_in;
		end
	end

	// Prescale divider runs only in master mode while a transfer is active.
	always @(posedge clk_i)
	begin
		if (srst_i || !mst || st_q == ST_IDLE || tick)
			div_q <= 9'd0;
		else
			div_q <= div_q + 9'd1;
	end

	// Register writes, buffer flags and the shift engine.
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			en_q   <= 1'b0;
			rov_q  <= 1'b0;
			tbf_q  <= 1'b0;
			rbf_q  <= 1'b0;
			cfga_q <= `SPC_RST_VAL;
			cfgb_q <= `SPC_RST_VAL;
			txb_q  <= `SPC_RST_VAL;
			rxb_q  <= `SPC_RST_VAL;
			st_q   <= ST_IDLE;
			sr_q   <= 16'h0000;
			bit_q  <= 5'd0;
			ph_q   <= 1'b0;
			smp_q  <= 1'b0;
			done_q <= 1'b0;
			sck_o  <= 1'b0;
			sdo_o  <= 1'b0;
			ss_o   <= 1'b1;
		end
		else
		begin
			done_q <= 1'b0;
			// Configuration writes; unimplemented bits are never stored.
			if (wr_i && addr_i == `SPC_OFS_STAT)
			begin
				en_q <= wdata_i[`SPC_ST_EN]; // RL21
				if (!wdata_i[`SPC_ST_ROV])
					rov_q <= 1'b0;
			end
			if (wr_i && addr_i == `SPC_OFS_CFG_A)
				cfga_q <= wdata_i & `SPC_A_MASK; // RL20
			if (wr_i && addr_i == `SPC_OFS_CFG_B)
				cfgb_q <= wdata_i & `SPC_B_MASK; // RL20
			// Transmit buffer write marks it full.
			if (wr_data)
			begin
				txb_q <= wdata_i;
				tbf_q <= 1'b1; // RL23
			end
			// Reading the data buffer empties the receive side.
			if (rd_data)
				rbf_q <= 1'b0; // RL24
			// A completed word: load the buffer or flag overflow; set wins clear.
			if (done_q)
			begin
				if (rbf_q)
					rov_q <= 1'b1; // RL22
				else
				begin
					rxb_q <= sr_q;
					rbf_q <= 1'b1; // RL24
				end
			end
			// Idle clock level follows polarity.
			if (st_q == ST_IDLE)
				sck_o <= cpol; // RL8
			if (!en_q)
			begin
				st_q <= ST_IDLE;
				ss_o <= ~fspol;
			end
			else
			begin
				case (st_q)
					ST_IDLE:
					begin
						ss_o <= ~fspol; // RL17
						ph_q <= 1'b0;
						// Master or any port not taking sync input starts on data; framed slave with sync input waits.
						if (start_ok && (mst || !frm || !fsdir))
						begin
							sr_q  <= w16 ? txb_q : {txb_q[7:0], 8'h00};
							tbf_q <= wr_data; // RL23
							bit_q <= nbits;
							if (!cke)
								sdo_o <= 1'b0;
							else
								sdo_o <= w16 ? txb_q[15] : txb_q[7];
							if (frm && !fsdir && !fslate)
							begin
								ss_o <= fspol; // RL18
								st_q <= ST_SYNC;
							end
							else
							begin
								if (frm && !fsdir)
									ss_o <= fspol; // RL18
								st_q <= ST_XFER;
							end
						end
						else if (frm && fsdir && fs_rise && start_ok)
						begin
							sr_q  <= w16 ? txb_q : {txb_q[7:0], 8'h00}; // RL16
							tbf_q <= wr_data;
							bit_q <= nbits;
							sdo_o <= w16 ? txb_q[15] : txb_q[7];
							st_q  <= ST_XFER;
						end
					end
					ST_SYNC:
					begin
						// Early sync holds one bit time before the first clock.
						if (tick)
						begin
							ph_q <= ~ph_q;
							if (ph_q)
							begin
								ss_o <= ~fspol;
								st_q <= ST_XFER;
							end
						end
					end
					ST_XFER:
					begin
						if (mst && tick)
						begin
							ph_q  <= ~ph_q;
							sck_o <= ph_q ? cpol : ~cpol; // RL8
							if (ph_q)
								ss_o <= ~fspol;
						end
						// The input bit is held apart so that it never overwrites a bit
						// that is still to be sent; a master with late sampling takes it
						// at the end of the output period instead of the middle.
						if ((mst && input_sample_phase) ? e_shift : e_cap)
							smp_q <= sdi_s_q[1]; // RL4
						// Each shift edge sends one bit and moves the held input in.
						if (e_shift && bit_q != 5'd0)
						begin
							bit_q <= bit_q - 5'd1;
							sr_q  <= {sr_q[14:0], smp_q};
							sdo_o <= cke ? sr_q[14] : sr_q[15]; // RL6
						end
						// Leading-edge output: the last capture edge ends the word and
						// its bit goes straight in. Trailing-edge output ends at once.
						if (!cke && bit_q == 5'd0 && e_cap)
						begin
							sr_q   <= {sr_q[14:0], sdi_s_q[1]}; // RL3
							done_q <= 1'b1;
							st_q   <= ST_IDLE;
						end
						else if (cke && bit_q == 5'd0)
						begin
							done_q <= 1'b1;
							st_q   <= ST_IDLE;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Registered read data, one cycle after the read strobe.
	always @(posedge clk_i)
	begin
		if (srst_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
		begin
			case (addr_i)
				`SPC_OFS_STAT:  rdata_o <= {en_q, 8'h00, rov_q, 4'h0, tbf_q, rbf_q};
				`SPC_OFS_CFG_A: rdata_o <= cfga_q; // RL20
				`SPC_OFS_CFG_B: rdata_o <= cfgb_q; // RL20
				`SPC_OFS_DATA:  rdata_o <= w16 ? rxb_q : {8'h00, rxb_q[7:0]};
				default:        rdata_o <= 16'h0000;
			endcase
		end
	end

endmodule

// [spc_port_chk.sv]
/* Assertions on the serial port's register reads and pin enables.
   Assumes one clock domain and the port's own top-level ports. */
`timescale 1ns/1ps
module spc_port_chk
(
	input wire        clk_i,
	input wire        srst_i,
	input wire [3:0]  addr_i,
	input wire [15:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [15:0] rdata_o,
	input wire        sck_oe_n_o,
	input wire        sdo_oe_n_o,
	input wire        ss_oe_n_o
);
	reg [15:0] cfg_q;  // Shadow of configuration register A.
	reg        en_q;   // Shadow of the module enable bit.
	reg        calm_q; // High when no write was taken one edge earlier.
	// Shadows follow writes; calm_q allows the design one cycle to react.
	always @(posedge clk_i)
	begin
		calm_q <= !wr_i;
		if (srst_i)
		begin
			cfg_q <= 16'h0000;
			en_q  <= 1'b0;
		end
		else if (wr_i && addr_i == 4'h1)
			cfg_q <= wdata_i;
		else if (wr_i && addr_i == 4'h0)
			en_q <= wdata_i[15];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	rst_vals_a: assert property ($fell(srst_i) |-> rdata_o == 16'h0000 && sck_oe_n_o
		&& sdo_oe_n_o && ss_oe_n_o) else $error("pins or data not at reset state");
	cfga_zero_a: assert property (rd_i && addr_i == 4'h1 |=> rdata_o[15:13] == 3'b000)
		else $error("config A spare bits set");
	cfgb_zero_a: assert property (rd_i && addr_i == 4'h2 |=> (rdata_o & 16'h1FFD) == 0)
		else $error("config B spare bits set");
	cfga_back_a: assert property (wr_i && addr_i == 4'h1 ##2 rd_i && addr_i == 4'h1
		|=> rdata_o == ($past(wdata_i, 3) & 16'h1FFF)) else $error("config A readback");
	sdo_off_a: assert property (calm_q && cfg_q[11] |-> sdo_oe_n_o)
		else $error("data pin driven while disabled");
	sdo_on_a: assert property (calm_q && en_q && !cfg_q[11] |-> !sdo_oe_n_o)
		else $error("data pin not driven");
	sck_off_a: assert property (calm_q && cfg_q[5] && cfg_q[12] |-> sck_oe_n_o)
		else $error("clock pin driven while disabled");
	sck_on_a: assert property (calm_q && en_q && cfg_q[5] && !cfg_q[12] |-> !sck_oe_n_o)
		else $error("master clock pin not driven");
	port_off_a: assert property (calm_q && !en_q |-> sck_oe_n_o && sdo_oe_n_o && ss_oe_n_o)
		else $error("pin driven while port off");
endmodule
bind spc_port spc_port_chk u_chk(.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.sck_oe_n_o(sck_oe_n_o), .sdo_oe_n_o(sdo_oe_n_o), .ss_oe_n_o(ss_oe_n_o));

// [spc_peer.sv]
/* Far serial device: shifts a word out MSB first and collects one in.
   Assumes it is rearmed by ld_i before every transfer. */
`timescale 1ns/1ps
module spc_peer
(
	input wire        sck_i,  // Clock pin level.
	input wire        mosi_i, // Data from the port.
	input wire        cpol_i, // Idle clock level.
	input wire        w16_i,  // Sixteen-bit words when high.
	input wire        ld_i,   // Rearm pulse.
	input wire [15:0] tx_i,   // Word to send.
	output reg        miso_o, // Data to the port.
	output reg [15:0] rx_o    // Collected bits, newest lowest.
);
	integer n; // Index of the next bit to send.
	initial miso_o = 1'b1;
	// Leaving idle puts out a bit; once all are sent the line toggles.
	always @(posedge ld_i or posedge sck_i or negedge sck_i)
		if (ld_i)
			n = w16_i ? 15 : 7;
		else if (sck_i != cpol_i)
		begin
			miso_o = n < 0 ? ~miso_o : tx_i[n];
			n = n - 1;
		end
		else
			rx_o = {rx_o[14:0], mosi_i};
endmodule

// [tb.sv]
/* Self-checking bench for the serial port as master and slave.
   Assumes spc_peer plays the far device on the serial pins. */
`timescale 1ns/1ps
module tb;
	reg         clk_i   = 1'b0;
	reg         srst_i  = 1'b1;
	reg         wr_i    = 1'b0;
	reg         rd_i    = 1'b0;
	reg         sck_tb  = 1'b0;     // Clock given while the port is a slave.
	reg         ld      = 1'b0;     // Rearms the far device.
	reg [3:0]   addr_i  = 4'h0;
	reg [15:0]  wdata_i = 16'h0000;
	reg [15:0]  pc      = 16'h0000; // Mode the far device follows.
	reg [15:0]  tx      = 16'h0000; // Word the far device sends.
	wire [15:0] rdata_o;
	wire [15:0] rx;
	wire        sck_o, sck_oe_n_o, sdo_o, sdo_oe_n_o, miso;
	integer     n_mismatch = 0;
	integer     num_checks = 0;
	wire        sck_w = sck_oe_n_o ? sck_tb : sck_o; // Clock pin level.
	wire        sdo_w = sdo_oe_n_o ? 1'b1 : sdo_o;   // Data pin, pulled up.
	always #10 clk_i = ~clk_i;
	spc_port u_dut(.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_n_o(sck_oe_n_o), .sdi_i(miso), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
		.ss_i(1'b1), .ss_o(), .ss_oe_n_o());
	spc_peer u_peer(.sck_i(sck_w), .mosi_i(sdo_w), .cpol_i(pc[6]), .w16_i(pc[10]),
		.ld_i(ld), .tx_i(tx), .miso_o(miso), .rx_o(rx));
	task chk(input [15:0] got, input [15:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	end
	endtask
	task rd(input [3:0] a, output [15:0] d);
	begin
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	end
	endtask
	// One transfer; a master's clock period is measured, a slave is clocked here.
	task xfer(input [15:0] cfg, input [15:0] d, input [15:0] t, input [15:0] per);
		reg [15:0] v;
		reg [15:0] m;
		time       t0;
	begin
		v  = 16'h0000;
		m  = cfg[10] ? 16'hFFFF : 16'h00FF;
		tx = t;
		pc = cfg;
		wr(4'h1, cfg);
		wr(4'h0, 16'h8000);
		ld <= 1'b1;
		@(posedge clk_i);
		ld <= 1'b0;
		#1 chk(sck_w, cfg[6]);
		wr(4'h3, d);
		if (cfg[5])
		begin
			@(posedge sck_w);
			t0 = $time;
			@(posedge sck_w);
			v = ($time - t0) / 20;
			chk(v, per);
			v = 16'h0000;
		end
		else
		begin
			repeat (16)
			begin
				repeat (4) @(posedge clk_i);
				sck_tb <= ~sck_tb;
			end
		end
		repeat (400) if (!v[0]) rd(4'h0, v);
		chk(v & 16'h0003, 16'h0001);
		rd(4'h3, v);
		chk(v & m, t & m);
		chk(rx & m, d & m);
		rd(4'h0, v);
		chk(v[0], 1'b0);
		wr(4'h0, 16'h0000);
	end
	endtask
	// Registers: reset values, spare bits, unmapped index.
	task t_regs;
		reg [15:0] v;
	begin
		rd(4'h0, v);
		chk(v, 16'h0000);
		wr(4'h1, 16'hFFFF);
		rd(4'h1, v);
		chk(v, 16'h1FFF);
		wr(4'h1, 16'h0000);
		wr(4'h2, 16'hFFFE);
		rd(4'h2, v);
		chk(v, 16'hE002);
		wr(4'h2, 16'h0000);
		wr(4'h5, 16'hFFFF);
		rd(4'h5, v);
		chk(v, 16'h0000);
	end
	endtask
	// Byte master, prescale 1 by 4, so eight cycles a bit.
	task t_master8;
		xfer(16'h0033, 16'h00A5, 16'h005A, 16'h0008);
	endtask
	// Word master, idle-high clock, prescale 4 by 2.
	task t_master16;
		xfer(16'h047A, 16'hC3A5, 16'h96E1, 16'h0010);
	endtask
	// Byte slave with slowest prescale codes, clocked from outside.
	task t_slave;
		xfer(16'h0000, 16'h0096, 16'h003C, 16'h0000);
	endtask
	task final_report;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// Main sequence.
	initial
	begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		t_regs;
		t_master8;
		t_master16;
		t_slave;
		final_report;
	end
	// Watchdog against a hang.
	initial
	begin
		#400000;
		n_mismatch = n_mismatch + 1;
		final_report;
	end
endmodule
